// ### core/odc_output_channel.sv
// Configuration registers and clock path of one output channel.
// Assumes a serial configuration port front end that presents single-cycle
// register reads and writes on clk, and clk being the selected VCO clock.
//
// Overview of operation
// - 20-bit divider built from three registers: four high bits and two bytes
// - Coarse delay of 0 to 63 VCO periods
// - Two-bit fine delay, 30 ps steps
// - Extra misc bit extends fine code to three
// - Decode three-bit driver standard field
// - Decode four-bit termination and single-ended code
// - Route single-ended phases by two-bit select
`timescale 1ns/1ns
`include "odc_regs.svh"

module odc_output_channel
   import odc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_write,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_read,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   output logic             positive_output_pin,
   output logic             positive_output_pin_oe,
   output logic             negative_output_pin,
   output logic             negative_output_pin_oe,
   output odc_drv_t         driver_standard_select,
   output odc_term_t        termination_mode,
   output logic [2:0]       drive_strength,
   output logic [2:0]       fine_delay_code,
   output logic             differential_mode
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [`ODC_DIV_HIGH_MSB:0] div_high_q;
   logic [7:0]                 div_mid_q;
   logic [7:0]                 div_low_q;
   logic [1:0]                 phase_sel_q;
   logic [`ODC_STRENGTH_MSB:0] strength_q;
   logic [7:0]                 delay_q;
   logic [`ODC_DRV_MSB:0]      drv_q;
   logic                       fine_ext_q;
   logic [`ODC_TERM_MSB:0]     term_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         div_high_q  <= '0;
         div_mid_q   <= `ODC_REG_RESET;
         div_low_q   <= `ODC_REG_RESET;
         phase_sel_q <= '0;
         strength_q  <= '0;
         delay_q     <= `ODC_REG_RESET;
         drv_q       <= '0;
         fine_ext_q  <= 1'b0;
         term_q      <= '0;
      end else if (reg_write) begin
         case (reg_addr)
            `ODC_OFF_DIV_HIGH: begin
               div_high_q <= reg_wdata[`ODC_DIV_HIGH_MSB:0];
            end
            `ODC_OFF_DIV_MID: begin
               div_mid_q <= reg_wdata;
            end
            `ODC_OFF_DIV_LOW: begin
               div_low_q <= reg_wdata;
            end
            `ODC_OFF_SE_PHASE: begin
               phase_sel_q <= reg_wdata[`ODC_PHASE_MSB:`ODC_PHASE_LSB];
               // Strength is stored as written; seven is expected
               strength_q  <= reg_wdata[`ODC_STRENGTH_MSB:0];
            end
            `ODC_OFF_DELAY: begin
               delay_q <= reg_wdata;
            end
            `ODC_OFF_DRV_STD: begin
               drv_q <= reg_wdata[`ODC_DRV_MSB:0];
            end
            `ODC_OFF_TERM_EXT: begin
               fine_ext_q <= reg_wdata[`ODC_FINE_EXT_BIT];
               term_q     <= reg_wdata[`ODC_TERM_MSB:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Readback
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_mux(input logic [7:0] addr);
      case (addr)
         `ODC_OFF_DIV_HIGH: read_mux = {4'h0, div_high_q};
         `ODC_OFF_DIV_MID:  read_mux = div_mid_q;
         `ODC_OFF_DIV_LOW:  read_mux = div_low_q;
         `ODC_OFF_SE_PHASE: read_mux = {phase_sel_q, 3'h0, strength_q};
         `ODC_OFF_DELAY:    read_mux = delay_q;
         `ODC_OFF_DRV_STD:  read_mux = {5'h00, drv_q};
         `ODC_OFF_TERM_EXT: read_mux = {3'h0, fine_ext_q, term_q};
         default:           read_mux = 8'h00;
      endcase
   endfunction

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= read_mux(reg_addr);
         end
      end
   end

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   logic [`ODC_DIV_W-1:0] divide_value;
   logic                  clk_div;

   assign divide_value = {div_high_q, div_mid_q, div_low_q};

   odc_divider u_divider (
      .clk     (clk),
      .reset   (reset),
      .divide  (divide_value),
      .clk_div (clk_div)
   );

   // ----------------------------------------------------------------
   // Coarse delay
   // ----------------------------------------------------------------
   // Code zero bypasses the line and adds nothing; tap 0 is one period late, so code n uses tap n-1
   logic [`ODC_COARSE_DEPTH-1:0] delay_line_q;
   logic                         clk_delayed;

   always_ff @(posedge clk) begin
      if (reset) begin
         delay_line_q <= '0;
      end else begin
         delay_line_q <= {delay_line_q[`ODC_COARSE_DEPTH-2:0], clk_div};
      end
   end

   always_comb begin
      if (delay_q[`ODC_COARSE_MSB:0] == 6'h00) begin
         clk_delayed = clk_div;
      end else begin
         clk_delayed = delay_line_q[delay_q[`ODC_COARSE_MSB:0] - 6'h01];
      end
   end

   // ----------------------------------------------------------------
   // Fine delay code to the analog trim
   // ----------------------------------------------------------------
   // Codes above four are passed on; the trim saturates at four steps
   always_ff @(posedge clk) begin
      if (reset) begin
         fine_delay_code <= 3'h0;
      end else begin
         fine_delay_code <= {fine_ext_q,
                             delay_q[`ODC_FINE_MSB:`ODC_FINE_LSB]};
      end
   end

   // ----------------------------------------------------------------
   // Driver standard and termination decode
   // ----------------------------------------------------------------
   function automatic odc_term_t term_decode(input logic [3:0] code);
      case (code)
         4'h0:    term_decode = ODC_TERM_EXTERNAL;
         4'h2:    term_decode = ODC_TERM_PULL_UP;
         4'h1:    term_decode = ODC_TERM_PULL_DOWN;
         4'h4:    term_decode = ODC_TERM_SE_POS;
         4'h8:    term_decode = ODC_TERM_SE_NEG;
         4'hC:    term_decode = ODC_TERM_SE_BOTH;
         default: term_decode = ODC_TERM_INVALID;
      endcase
   endfunction

   odc_term_t term_now;
   assign term_now = term_decode(term_q);

   always_ff @(posedge clk) begin
      if (reset) begin
         driver_standard_select <= ODC_DRV_LVDS;
         termination_mode       <= ODC_TERM_EXTERNAL;
         drive_strength         <= 3'h0;
      end else begin
         case (drv_q)
            3'h0:    driver_standard_select <= ODC_DRV_LVDS;
            3'h1:    driver_standard_select <= ODC_DRV_LVPECL_CM;
            3'h2:    driver_standard_select <= ODC_DRV_CML;
            3'h3:    driver_standard_select <= ODC_DRV_HCSL;
            3'h4:    driver_standard_select <= ODC_DRV_LVDS_BOOST;
            3'h5:    driver_standard_select <= ODC_DRV_LVPECL_NOCM;
            default: driver_standard_select <= ODC_DRV_RESERVED;
         endcase
         termination_mode <= term_now;
         drive_strength   <= strength_q;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive and phase routing
   // ----------------------------------------------------------------
   logic positive_pin_drive_source;
   logic negative_pin_drive_source;
   logic se_mode;

   assign se_mode = (term_now == ODC_TERM_SE_POS) ||
                    (term_now == ODC_TERM_SE_NEG) ||
                    (term_now == ODC_TERM_SE_BOTH);

   always_comb begin
      if (se_mode) begin
         case (odc_phase_t'(phase_sel_q))
            ODC_PH_TRUE_COMP: begin
               positive_pin_drive_source = clk_delayed;
               negative_pin_drive_source = ~clk_delayed;
            end
            ODC_PH_TRUE_TRUE: begin
               positive_pin_drive_source = clk_delayed;
               negative_pin_drive_source = clk_delayed;
            end
            ODC_PH_COMP_COMP: begin
               positive_pin_drive_source = ~clk_delayed;
               negative_pin_drive_source = ~clk_delayed;
            end
            default: begin
               positive_pin_drive_source = ~clk_delayed;
               negative_pin_drive_source = clk_delayed;
            end
         endcase
      end else begin
         positive_pin_drive_source = clk_delayed;
         negative_pin_drive_source = ~clk_delayed;
      end
   end

   // Pins retimed so the driver sees no decode glitches
   always_ff @(posedge clk) begin
      if (reset) begin
         positive_output_pin    <= 1'b0;
         negative_output_pin    <= 1'b0;
         positive_output_pin_oe <= 1'b0;
         negative_output_pin_oe <= 1'b0;
         differential_mode      <= 1'b0;
      end else begin
         positive_output_pin    <= positive_pin_drive_source;
         negative_output_pin    <= negative_pin_drive_source;
         positive_output_pin_oe <= ~se_mode ||
                                   (term_now != ODC_TERM_SE_NEG);
         negative_output_pin_oe <= ~se_mode ||
                                   (term_now != ODC_TERM_SE_POS);
         differential_mode      <= ~se_mode;
      end
   end

endmodule // odc_output_channel

// ### core/odc_regs.svh
// Register offsets, field positions and reset values of one output channel.
// Assumes inclusion by the top module of the channel, the divider and the checker.
`ifndef ODC_REGS_SVH
`define ODC_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ODC_OFF_DIV_HIGH    8'h28
`define ODC_OFF_DIV_MID     8'h29
`define ODC_OFF_DIV_LOW     8'h2A
`define ODC_OFF_SE_PHASE    8'h2B
`define ODC_OFF_DELAY       8'h2C
`define ODC_OFF_DRV_STD     8'h2D
`define ODC_OFF_TERM_EXT    8'h2F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ODC_DIV_HIGH_MSB    3
`define ODC_PHASE_MSB       7
`define ODC_PHASE_LSB       6
`define ODC_STRENGTH_MSB    2
`define ODC_COARSE_MSB      5
`define ODC_FINE_MSB        7
`define ODC_FINE_LSB        6
`define ODC_DRV_MSB         2
`define ODC_FINE_EXT_BIT    4
`define ODC_TERM_MSB        3

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define ODC_DIV_W           20
`define ODC_COARSE_DEPTH    64
`define ODC_REG_RESET       8'h00
`define ODC_DIV_MIN         20'h00002
`define ODC_FINE_STEP_PS    30

`endif

// ### core/odc_pkg.sv
// Types shared by the output channel configuration logic.
// Assumes odc_regs.svh is on the include path.
package odc_pkg;

   // ----------------------------------------------------------------
   // Driver standards
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ODC_DRV_LVDS         = 3'h0,
      ODC_DRV_LVPECL_CM    = 3'h1,
      ODC_DRV_CML          = 3'h2,
      ODC_DRV_HCSL         = 3'h3,
      ODC_DRV_LVDS_BOOST   = 3'h4,
      ODC_DRV_LVPECL_NOCM  = 3'h5,
      ODC_DRV_RESERVED     = 3'h7
   } odc_drv_t;

   // ----------------------------------------------------------------
   // Termination and single-ended modes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ODC_TERM_EXTERNAL    = 3'h0,
      ODC_TERM_PULL_UP     = 3'h1,
      ODC_TERM_PULL_DOWN   = 3'h2,
      ODC_TERM_SE_POS      = 3'h3,
      ODC_TERM_SE_NEG      = 3'h4,
      ODC_TERM_SE_BOTH     = 3'h5,
      ODC_TERM_INVALID     = 3'h7
   } odc_term_t;

   // ----------------------------------------------------------------
   // Single-ended phase routing
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ODC_PH_TRUE_COMP     = 2'h0,
      ODC_PH_TRUE_TRUE     = 2'h1,
      ODC_PH_COMP_COMP     = 2'h2,
      ODC_PH_SWAPPED       = 2'h3
   } odc_phase_t;

endpackage

// ### core/odc_divider.sv
// Integer clock divider producing a square wave enable-free level.
// Assumes the source clock is the selected VCO clock; divide must be >= 2.
`timescale 1ns/1ns
`include "odc_regs.svh"

module odc_divider
   import odc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [`ODC_DIV_W-1:0]  divide,
   output logic                        clk_div
);

   logic [`ODC_DIV_W-1:0] count_q;
   logic                  active;

   // Values 0 and 1 cannot be built from logic; the output idles low
   assign active = (divide >= `ODC_DIV_MIN);

   // ----------------------------------------------------------------
   // Period counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || !active || (count_q >= divide - 20'h00001)) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 20'h00001;
      end
   end

   // High for the first half; odd values give one extra low cycle
   always_ff @(posedge clk) begin
      if (reset || !active) begin
         clk_div <= 1'b0;
      end else begin
         clk_div <= (count_q < (divide >> 1));
      end
   end

endmodule // odc_divider

// ### tb/odc_output_channel_properties.sv
// Port-level assertions for one output channel.
// Assumes binding to odc_output_channel on a single clock.
`timescale 1ns/1ns
`include "odc_regs.svh"

module odc_output_channel_properties
   import odc_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_write,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        positive_output_pin,
   input wire logic        positive_output_pin_oe,
   input wire logic        negative_output_pin,
   input wire logic        negative_output_pin_oe,
   input wire odc_term_t   termination_mode,
   input wire logic [2:0]  fine_delay_code,
   input wire logic        differential_mode
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_wr(a);
      reg_write && reg_addr == a;
   endsequence

   chk_read_answer: assert property (reg_read |=> reg_rvalid)
      else $error("read gave no rvalid");
   chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_read))
      else $error("rvalid without a read");
   chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
      else $error("rdata moved without a read");
   chk_write_readback: assert property (s_wr(`ODC_OFF_DELAY) ##1
      reg_read && reg_addr == `ODC_OFF_DELAY |=> reg_rdata == $past(reg_wdata, 2))
      else $error("delay readback differs");
   chk_fine_low: assert property (s_wr(`ODC_OFF_DELAY) ##1 !reg_write
      |-> ##1 fine_delay_code[1:0] == $past(reg_wdata[7:6], 2))
      else $error("fine code low bits wrong");
   chk_fine_ext: assert property (s_wr(`ODC_OFF_TERM_EXT) ##1 !reg_write
      |-> ##1 fine_delay_code[2] == $past(reg_wdata[4], 2))
      else $error("fine code top bit wrong");
   chk_diff_pair: assert property (differential_mode [*4] |->
      positive_output_pin_oe && negative_output_pin_oe &&
      negative_output_pin != positive_output_pin)
      else $error("differential pair broken");
   chk_se_pos_only: assert property ((termination_mode == ODC_TERM_SE_POS)
      [*4] |-> positive_output_pin_oe && !negative_output_pin_oe)
      else $error("positive-only drive wrong");
   chk_se_neg_only: assert property ((termination_mode == ODC_TERM_SE_NEG)
      [*4] |-> !positive_output_pin_oe && negative_output_pin_oe)
      else $error("negative-only drive wrong");
   chk_mode_map: assert property ($stable(termination_mode) [*3] |->
      differential_mode == !(termination_mode inside
      {ODC_TERM_SE_POS, ODC_TERM_SE_NEG, ODC_TERM_SE_BOTH}))
      else $error("differential flag disagrees");
endmodule // odc_output_channel_properties

bind odc_output_channel odc_output_channel_properties u_props (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
   .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .positive_output_pin(positive_output_pin),
   .positive_output_pin_oe(positive_output_pin_oe),
   .negative_output_pin(negative_output_pin),
   .negative_output_pin_oe(negative_output_pin_oe),
   .termination_mode(termination_mode), .fine_delay_code(fine_delay_code),
   .differential_mode(differential_mode)
);

// ### tb/odc_output_channel_bench.sv
// Self-checking bench: register model, field decodes and output clock.
// Assumes the core files and the checker are compiled before it.
`timescale 1ns/1ns

module odc_output_channel_bench
   import odc_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_write = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_read = 1'b0;
   logic [7:0]  reg_rdata, lfsr = 8'h4B;
   logic        reg_rvalid, pos, pos_oe, neg, neg_oe, diff;
   odc_drv_t    drv;
   odc_term_t   term;
   logic [2:0]  strength, fine;
   int          errors = 0, checked = 0, cyc = 0, ph0 = 0, i, p;
   int          mdl [0:255] = '{default: 0};
   int          tmap [16] = '{0, 2, 1, 7, 3, 7, 7, 7, 4, 7, 7, 7, 5, 7, 7, 7};
   logic [7:0]  offs [9] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
                            8'h2F, 8'h2E, 8'h00};

   odc_output_channel u_dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .positive_output_pin(pos),
      .positive_output_pin_oe(pos_oe), .negative_output_pin(neg),
      .negative_output_pin_oe(neg_oe), .driver_standard_select(drv),
      .termination_mode(term), .drive_strength(strength),
      .fine_delay_code(fine), .differential_mode(diff)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial forever #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   function automatic int msk(input logic [7:0] a);
      case (a)
         8'h28: return 'h0F;
         8'h29, 8'h2A, 8'h2C: return 'hFF;
         8'h2B: return 'hC7;
         8'h2D: return 'h07;
         8'h2F: return 'h1F;
         default: return 0;
      endcase
   endfunction

   task automatic cmp(input string what, input logic [19:0] e, g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", what, e, g);
      end
   endtask

   task automatic bus(input logic w, r, input logic [7:0] a, d);
      @(negedge clk);
      reg_write = w;
      reg_read = r;
      reg_addr = a;
      reg_wdata = d;
   endtask

   task automatic wr(input logic [7:0] a, d);
      bus(1'b1, 1'b0, a, d);
      mdl[a] = d & msk(a);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, 1'b1, a, 8'h00);
      @(posedge clk);
      #1;
      cmp("rvalid", 1, reg_rvalid);
      cmp("rdata", mdl[a], reg_rdata);
   endtask

   task automatic idle(input int n);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (n) @(negedge clk);
   endtask

   task automatic chk_dec();
      int t;
      t = mdl['h2F] & 15;
      idle(6);
      cmp("drv", (mdl['h2D] < 6) ? mdl['h2D] : 7, drv);
      cmp("term", tmap[t], term);
      cmp("diff", !(t inside {4, 8, 12}), diff);
      cmp("fine", {mdl['h2F][4], mdl['h2C][7:6]}, fine);
      cmp("strength", mdl['h2B] & 7, strength);
   endtask

   task automatic lvl(input logic v, output int t);
      int k;
      for (k = 0; k < 1000 && pos !== v; k++)
         @(negedge clk);
      t = cyc;
   endtask

   // Settle long enough for divider and delay line to flush
   task automatic clk_check(input int n, off);
      int r1, f, r2, d;
      idle(450);
      lvl(1'b0, d);
      lvl(1'b1, r1);
      lvl(1'b0, f);
      lvl(1'b1, r2);
      cmp("period", n, r2 - r1);
      cmp("high", n / 2, f - r1);
      if (off < 0)
         ph0 = r1 % 200;
      else if (n == 200)
         cmp("phase", (ph0 + off) % 200, r1 % 200);
   endtask

   task automatic stop_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      foreach (offs[k])
         rd(offs[k]);
      for (i = 0; i < 40; i++) begin
         lfsr = nxt(lfsr);
         wr(offs[lfsr % 9], nxt(lfsr));
         rd(offs[lfsr % 9]);
         chk_dec();
      end
      for (i = 0; i < 16; i++) begin
         lfsr = nxt(lfsr);
         wr(8'h2F, {3'h0, lfsr[0], i[3:0]});
         wr(8'h2D, {5'h00, i[2:0]});
         chk_dec();
      end
      wr(8'h28, 8'h00);
      wr(8'h29, 8'h00);
      wr(8'h2A, 8'hC8);
      wr(8'h2B, 8'h07);
      wr(8'h2C, 8'h00);
      wr(8'h2F, 8'h00);
      clk_check(200, -1);
      wr(8'h2C, 8'h25);
      clk_check(200, 37);
      wr(8'h2C, 8'h3F);
      clk_check(200, 63);
      wr(8'h2C, 8'h00);
      wr(8'h2F, 8'h0C);
      for (p = 0; p < 4; p++) begin
         wr(8'h2B, {p[1:0], 6'h07});
         clk_check(200, p[1] ? 100 : 0);
         // Logical not keeps the expected value one bit wide
         cmp("neg", (p == 1 || p == 2) ? pos : !pos, neg);
         cmp("oe", 2'h3, {pos_oe, neg_oe});
      end
      // True phase on the positive pin again, else high time is inverted
      wr(8'h2B, 8'h07);
      wr(8'h2A, 8'h05);
      clk_check(5, 0);
      stop_test();
   end

   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule // odc_output_channel_bench
